// File: cbm_consts.svh
// How it works
// - boost code weights 64mV steps above 4.55V, default 0111
// - hot code picks 33, 36, 30 percent or off
// - hot code 11 disables cutoff, thermistor uses 33 percent
// - thermal threshold codes 60 to 120 C, reset 11
// - host starts detection, device clears when finished
// - slowdown bit halves safety timer during input power limiting or thermal regulation
// - switch-off bit opens battery switch after 7-11 s
// - upper enable gates charge fault interrupt
// - lower enable gates battery overvoltage interrupt
// - misc register resets to 01001011
// - fault register latches, read clears to present faults
// - charge fault codes; adapter removal reports input once
`ifndef CBM_CONSTS_SVH
`define CBM_CONSTS_SVH

`define CBM_ADDR_BOOST_CFG 8'h06
`define CBM_ADDR_MISC 8'h07
`define CBM_ADDR_FAULT 8'h09

`define CBM_BOOST_CFG_RESET 8'h73
`define CBM_MISC_RESET 8'h4B

`define CBM_BOOST_CODE_MSB 7
`define CBM_BOOST_CODE_LSB 4
`define CBM_HOT_CODE_MSB 3
`define CBM_HOT_CODE_LSB 2
`define CBM_THERM_THR_MSB 1
`define CBM_THERM_THR_LSB 0
`define CBM_MISC_DETECT 7
`define CBM_MISC_HALF_RATE 6
`define CBM_MISC_SWITCH_OFF 5
`define CBM_MISC_INT_CHG 1
`define CBM_MISC_INT_BAT 0
`define CBM_FAULT_CHG_LSB 4
`define CBM_FAULT_BAT 3

`define CBM_BOOST_BASE_MV 4550
`define CBM_CHG_INPUT_FAULT 2'h1

`define CBM_CLK_KHZ 25000
`define CBM_SWITCH_OFF_DELAY_MS 9000
`define CBM_SWITCH_OFF_CYCLES (`CBM_SWITCH_OFF_DELAY_MS * `CBM_CLK_KHZ)

`endif

// File: cbm_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbm_consts.svh"
module cbm_control_regs #(
    parameter int unsigned SWITCH_OFF_CYCLES = `CBM_SWITCH_OFF_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_bus_power_present,
    input wire logic i_detect_done,
    input wire logic i_input_power_limiting,
    input wire logic i_thermal_regulation,
    input wire logic i_timer_tick,
    input wire logic [1:0] i_charge_fault_code,
    input wire logic i_battery_overvoltage_fault,
    input wire logic i_adapter_removed,
    output logic [12:0] o_boost_mv,
    output logic [1:0] o_boost_hot_level,
    output logic o_boost_thermal_protect_en,
    output logic [1:0] o_thermistor_hot_level,
    output logic [6:0] o_thermal_reg_degc,
    output logic o_detect_start,
    output logic o_safety_timer_advance,
    output logic o_battery_switch_on,
    output logic o_int
);
    cbm_pkg::cbm_state_type state_r;
    cbm_pkg::cbm_state_type state_nxt;
    logic switch_expired;
    logic wr_cfg;
    logic wr_misc;
    logic rd_fault;
    logic chg_event;
    logic bat_event;
    logic [1:0] chg_now;
    cbm_pkg::cbm_hot_level_type hot;

    cbm_delay_timer #(
        .CYCLES(SWITCH_OFF_CYCLES)
    ) u_switch_delay (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_request(state_r.misc[`CBM_MISC_SWITCH_OFF]),
        .o_expired(switch_expired)
    );

    assign wr_cfg = i_reg_wr && (i_reg_addr == `CBM_ADDR_BOOST_CFG);
    assign wr_misc = i_reg_wr && (i_reg_addr == `CBM_ADDR_MISC);
    assign rd_fault = i_reg_rd && (i_reg_addr == `CBM_ADDR_FAULT);
    // adapter removal shows as an input fault once
    assign chg_now = i_adapter_removed ? `CBM_CHG_INPUT_FAULT
                                       : i_charge_fault_code;
    assign chg_event = (chg_now != 2'h0) && (state_r.prev_chg == 2'h0);
    assign bat_event = i_battery_overvoltage_fault && !state_r.prev_bat;
    assign hot = cbm_pkg::cbm_hot_level_type'(
        state_r.boost_cfg[`CBM_HOT_CODE_MSB:`CBM_HOT_CODE_LSB]);

    always_comb begin
        state_nxt = state_r;
        state_nxt.detect_start = 1'b0;
        state_nxt.advance = 1'b0;
        state_nxt.prev_chg = chg_now;
        state_nxt.prev_bat = i_battery_overvoltage_fault;
        if (wr_cfg) begin
            state_nxt.boost_cfg = i_reg_wdata;
        end
        // done clears the start bit, a fresh write in the same cycle wins
        if (i_detect_done) begin
            state_nxt.misc[`CBM_MISC_DETECT] = 1'b0;
        end
        if (wr_misc) begin
            state_nxt.misc = i_reg_wdata;
            state_nxt.misc[`CBM_MISC_DETECT] =
                i_reg_wdata[`CBM_MISC_DETECT] && i_bus_power_present;
            state_nxt.detect_start =
                i_reg_wdata[`CBM_MISC_DETECT] && i_bus_power_present;
        end
        // fault latch: a read reloads with what is present now
        if (rd_fault) begin
            state_nxt.rdata = 8'h00;
            state_nxt.rdata[`CBM_FAULT_CHG_LSB +: 2] = state_r.fault_chg;
            state_nxt.rdata[`CBM_FAULT_BAT] = state_r.fault_bat;
            state_nxt.fault_chg = chg_now;
            state_nxt.fault_bat = i_battery_overvoltage_fault;
        end else begin
            if (state_r.fault_chg == 2'h0) begin
                state_nxt.fault_chg = chg_now;
            end
            state_nxt.fault_bat = state_r.fault_bat
                || i_battery_overvoltage_fault;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `CBM_ADDR_BOOST_CFG: state_nxt.rdata = state_r.boost_cfg;
                    `CBM_ADDR_MISC: state_nxt.rdata = state_r.misc;
                    default: state_nxt.rdata = 8'h00;
                endcase
            end
        end
        state_nxt.int_p = (chg_event && state_r.misc[`CBM_MISC_INT_CHG])
            || (bat_event && state_r.misc[`CBM_MISC_INT_BAT]);
        // every other tick is dropped while slowed
        if (i_timer_tick) begin
            if (state_r.misc[`CBM_MISC_HALF_RATE]
                && (i_input_power_limiting || i_thermal_regulation)) begin
                state_nxt.half_phase = !state_r.half_phase;
                state_nxt.advance = state_r.half_phase;
            end else begin
                state_nxt.advance = 1'b1;
            end
        end
        state_nxt.boost_mv = 13'(`CBM_BOOST_BASE_MV) + {3'h0,
            state_r.boost_cfg[`CBM_BOOST_CODE_MSB:`CBM_BOOST_CODE_LSB],
            6'h00};
        state_nxt.hot_level = hot;
        state_nxt.prot_en = (hot != cbm_pkg::CBM_HOT_OFF);
        state_nxt.ntc_level = (hot == cbm_pkg::CBM_HOT_OFF)
            ? cbm_pkg::CBM_HOT_33 : hot;
        case (state_r.boost_cfg[`CBM_THERM_THR_MSB:`CBM_THERM_THR_LSB])
            2'b00: state_nxt.thermal_reg_threshold_degc = 7'h3C;
            2'b01: state_nxt.thermal_reg_threshold_degc = 7'h50;
            2'b10: state_nxt.thermal_reg_threshold_degc = 7'h64;
            default: state_nxt.thermal_reg_threshold_degc = 7'h78;
        endcase
        state_nxt.switch_on = !switch_expired;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= '0;
            state_r.boost_cfg <= `CBM_BOOST_CFG_RESET;
            state_r.misc <= `CBM_MISC_RESET;
            state_r.boost_mv <= 13'h1386;
            state_r.prot_en <= 1'b1;
            state_r.thermal_reg_threshold_degc <= 7'h78;
            state_r.switch_on <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_reg_rdata = state_r.rdata;
    assign o_boost_mv = state_r.boost_mv;
    assign o_boost_hot_level = state_r.hot_level;
    assign o_boost_thermal_protect_en = state_r.prot_en;
    assign o_thermistor_hot_level = state_r.ntc_level;
    assign o_thermal_reg_degc = state_r.thermal_reg_threshold_degc;
    assign o_detect_start = state_r.detect_start;
    assign o_safety_timer_advance = state_r.advance;
    assign o_battery_switch_on = state_r.switch_on;
    assign o_int = state_r.int_p;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence s_allow;
        !state_r.misc[`CBM_MISC_SWITCH_OFF] [*2];
    endsequence
    sequence s_cfg_stable;
        $stable(state_r.boost_cfg) [*2];
    endsequence

    property p_boost_mv;
        s_cfg_stable |-> o_boost_mv == 13'(`CBM_BOOST_BASE_MV)
            + 13'(state_r.boost_cfg[7:4]) * 13'h40;
    endproperty
    a_boost_mv: assert property (p_boost_mv)
        else $error("boost voltage decode wrong");
    property p_hot_off;
        state_r.boost_cfg[3:2] == 2'b11 |=>
            !o_boost_thermal_protect_en && o_thermistor_hot_level == 2'b00;
    endproperty
    a_hot_off: assert property (p_hot_off)
        else $error("hot code 11 handling wrong");
    property p_hot_sel;
        state_r.boost_cfg[3:2] == 2'b10 |=> o_boost_hot_level == 2'b10
            && o_boost_thermal_protect_en;
    endproperty
    a_hot_sel: assert property (p_hot_sel)
        else $error("hot level select wrong");
    property p_thermal_reg_threshold;
        state_r.boost_cfg[1:0] == 2'b00 |=> o_thermal_reg_degc == 7'h3C;
    endproperty
    a_thermal_reg_threshold: assert property (p_thermal_reg_threshold)
        else $error("thermal threshold decode wrong");
    property p_detect_clear;
        i_detect_done && !wr_misc |=> !state_r.misc[7];
    endproperty
    a_detect_clear: assert property (p_detect_clear)
        else $error("detect bit not cleared");
    property p_half_rate;
        i_timer_tick && state_r.misc[6] && i_thermal_regulation
            && !state_r.half_phase |=> !o_safety_timer_advance;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("timer not slowed");
    property p_switch_on;
        s_allow |=> o_battery_switch_on;
    endproperty
    a_switch_on: assert property (p_switch_on)
        else $error("battery switch held off");
    property p_int_chg;
        chg_event && !state_r.misc[1] && !bat_event |=> !o_int;
    endproperty
    a_int_chg: assert property (p_int_chg)
        else $error("masked charge fault interrupt");
    property p_int_bat;
        bat_event && state_r.misc[0] |=> o_int;
    endproperty
    a_int_bat: assert property (p_int_bat)
        else $error("battery fault interrupt missing");
    property p_fault_read;
        rd_fault && state_r.fault_bat |=> o_reg_rdata[3];
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("latched fault not reported");
endmodule
`default_nettype wire

// File: cbm_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cbm_delay_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_request,
    output logic o_expired
);
    cbm_pkg::cbm_delay_state_type state_r;
    cbm_pkg::cbm_delay_state_type state_nxt;

    // request must stay high for the whole delay; dropping it restarts
    always_comb begin
        state_nxt = state_r;
        if (!i_request) begin
            state_nxt.count = 32'h0;
            state_nxt.expired = 1'b0;
        end else if (state_r.count >= CYCLES - 1) begin
            state_nxt.expired = 1'b1;
        end else begin
            state_nxt.count = state_r.count + 32'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_expired = state_r.expired;
endmodule
`default_nettype wire

// File: cbm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbm_host_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_rd
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd = 1'b0;
    end
    // one single-byte write, held for one full cycle; writing bit 7 of register 07h starts
    // port detection, but only while bus power is present
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask
    // reserved bits keep what was read back
    task automatic rmw(input logic [7:0] a, m, v);
        logic [7:0] d;
        rd(a, d);
        wr(a, (d & ~m) | v);
    endtask
endmodule
`default_nettype wire

// File: cbm_pkg.sv
`default_nettype none
package cbm_pkg;

    typedef enum logic [1:0] {
        CBM_HOT_33 = 2'b00,
        CBM_HOT_36 = 2'b01,
        CBM_HOT_30 = 2'b10,
        CBM_HOT_OFF = 2'b11
    } cbm_hot_level_type;

    typedef struct packed {
        logic [31:0] count;
        logic expired;
    } cbm_delay_state_type;

    typedef struct packed {
        logic [7:0] boost_cfg;
        logic [7:0] misc;
        logic [1:0] fault_chg;
        logic fault_bat;
        logic [1:0] prev_chg;
        logic prev_bat;
        logic half_phase;
        logic [7:0] rdata;
        logic detect_start;
        logic advance;
        logic int_p;
        logic [12:0] boost_mv;
        logic [1:0] hot_level;
        logic prot_en;
        logic [1:0] ntc_level;
        logic [6:0] thermal_reg_threshold_degc;
        logic switch_on;
    } cbm_state_type;

endpackage
`default_nettype wire

// File: test_charger_boost_misc_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_charger_boost_misc_control;
    logic clk = 1'b0, rst = 1'b1, rd_seen = 1'b0;
    logic bus_pw = 1'b0, done = 1'b0, lim = 1'b0, thr = 1'b0, tick = 1'b0;
    logic bat = 1'b0, adrm = 1'b0;
    logic [1:0] chg = 2'h0;
    logic [7:0] addr, wdata, rdata, lf, w, d;
    logic wr, rd, dstart, adv, sw_on, prot, intr;
    logic [12:0] mv;
    logic [1:0] hot, ntc;
    logic [6:0] degc;
    logic [7:0] exp_q[$];
    int n_errors = 0, check_count = 0, adv_n = 0, cyc = 0, base;
    always #20 clk = ~clk;
    cbm_host_model cbm_host_model_i (.i_clk_sys(clk), .i_reg_rdata(rdata),
        .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata), .o_reg_rd(rd));
    cbm_control_regs #(.SWITCH_OFF_CYCLES(20)) cbm_control_regs_i (
        .i_clk_sys(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_bus_power_present(bus_pw), .i_detect_done(done),
        .i_input_power_limiting(lim), .i_thermal_regulation(thr),
        .i_timer_tick(tick), .i_charge_fault_code(chg),
        .i_battery_overvoltage_fault(bat), .i_adapter_removed(adrm),
        .o_boost_mv(mv), .o_boost_hot_level(hot),
        .o_boost_thermal_protect_en(prot), .o_thermistor_hot_level(ntc),
        .o_thermal_reg_degc(degc), .o_detect_start(dstart),
        .o_safety_timer_advance(adv), .o_battery_switch_on(sw_on),
        .o_int(intr));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            n_errors++;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cbm_host_model_i.rd(a, d);
    endtask
    // every read of the host lands in the checker, so note it first
    task automatic rmwq(input logic [7:0] a, m, v, e);
        exp_q.push_back(e);
        cbm_host_model_i.rmw(a, m, v);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // read data appears one cycle after the read is taken
    always @(posedge clk) begin
        rd_seen <= rd;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report;
        end
    end
    // outputs are settled at the falling edge
    always @(negedge clk) begin
        if (adv === 1'b1)
            adv_n = adv_n + 1;
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0)
                chk(16'hFFFF, {8'h00, rdata});
            else
                chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
        end
    end
    initial begin
        lf = 8'h2A;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk(mv, 16'd4998);
        chk({hot, prot, ntc, sw_on}, 6'h09);
        chk(degc, 16'd120);
        rchk(8'h06, 8'h73);
        rchk(8'h07, 8'h4B);
        rchk(8'h09, 8'h00);
        rchk(8'h10, 8'h00);
        for (int c = 0; c < 16; c++) begin
            lf = lfsr(lf);
            w = {c[3:0], c[1:0], lf[1:0]};
            cbm_host_model_i.wr(8'h06, w);
            repeat (2) @(negedge clk);
            chk(mv, 16'(4550 + c * 64));
            chk({hot, prot}, {w[3:2], w[3:2] != 2'b11});
            chk(ntc, (w[3:2] == 2'b11) ? 2'b00 : w[3:2]);
            chk(degc, 16'(60 + 20 * w[1:0]));
            rchk(8'h06, w);
        end
        cbm_host_model_i.wr(8'h07, 8'hCB);
        chk(dstart, 1'b0);
        rchk(8'h07, 8'h4B);
        bus_pw = 1'b1;
        cbm_host_model_i.wr(8'h07, 8'hCB);
        chk(dstart, 1'b1);
        rchk(8'h07, 8'hCB);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        rchk(8'h07, 8'h4B);
        for (int k = 0; k < 4; k++) begin
            lim = (k == 1);
            thr = (k == 2);
            rmwq(8'h07, 8'h40, (k == 3) ? 8'h00 : 8'h40, 8'h4B);
            lim = (k != 0);
            base = adv_n;
            ticks(4);
            chk(16'(adv_n - base), (k == 0 || k == 3) ? 16'd4 : 16'd2);
        end
        lim = 1'b0;
        rmwq(8'h07, 8'h60, 8'h60, 8'h0B);
        repeat (10) @(negedge clk);
        chk(sw_on, 1'b1);
        repeat (20) @(negedge clk);
        chk(sw_on, 1'b0);
        rmwq(8'h07, 8'h20, 8'h00, 8'h6B);
        repeat (2) @(negedge clk);
        chk(sw_on, 1'b1);
        chg = 2'h1;
        @(negedge clk);
        chk(intr, 1'b1);
        chg = 2'h0;
        rchk(8'h09, 8'h10);
        rchk(8'h09, 8'h00);
        adrm = 1'b1;
        @(negedge clk);
        adrm = 1'b0;
        chk(intr, 1'b1);
        rchk(8'h09, 8'h10);
        rchk(8'h09, 8'h00);
        cbm_host_model_i.wr(8'h07, 8'h48);
        bat = 1'b1;
        chg = 2'h2;
        @(negedge clk);
        chk(intr, 1'b0);
        rchk(8'h09, 8'h28);
        bat = 1'b0;
        chg = 2'h0;
        cbm_host_model_i.wr(8'h07, 8'h49);
        bat = 1'b1;
        @(negedge clk);
        chk(intr, 1'b1);
        chg = 2'h3;
        @(negedge clk);
        chk(intr, 1'b0);
        chg = 2'h0;
        bat = 1'b0;
        // second reset in mid-run restores both registers
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(mv, 16'd4998);
        chk({hot, prot, ntc, sw_on}, 6'h09);
        chk(degc, 16'd120);
        rchk(8'h06, 8'h73);
        rchk(8'h07, 8'h4B);
        repeat (2) @(negedge clk);
        chk(exp_q.size(), 16'd0);
        final_report;
    end
endmodule
`default_nettype wire
